//--- design/mfe_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfe_defines.svh"

module mfe_encoder
    import mfe_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       master_rst,
    input  wire logic       enc_clk_in,
    output logic            div6_out,
    input  wire logic       send_clk_in,
    output logic            tx_bit_strobe_abbrev,
    input  wire logic       tx_enable,
    input  wire logic       sync_cmd_sel,
    input  wire logic       parity_odd_sel,
    input  wire logic       tx_payload_in_abbrev,
    output logic            send_data,
    input  wire logic       out_inhibit_n,
    input  wire logic       frame_len_bit0,
    input  wire logic       frame_len_bit1,
    input  wire logic       frame_len_bit2,
    input  wire logic       frame_len_bit3,
    input  wire logic       frame_len_bit4,
    output logic            line_pos_n,
    output logic            line_neg_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic       enc_clk_q_r;
    logic [2:0] div6_cnt_r;
    logic       div6_r;
    logic       send_clk_q_r;
    logic       shift_clk_r;
    mfe_state_t state_r;
    logic [4:0] period_r;
    logic [4:0] flen_r;
    logic [4:0] line_per_r;
    logic       line_on_r;
    logic       line_bit_r;
    logic       sync_cmd_r;
    logic       data_r;
    logic       par_acc_r;
    logic       pos_n_r;
    logic       neg_n_r;

    wire        enc_rise;
    wire        send_rise;
    wire        shift_fall;
    wire        shift_rise;
    wire [4:0]  flen_raw;
    wire [4:0]  flen_in;
    wire        last_period;
    wire        start_word;
    wire        in_sync;
    wire [2:0]  sync_half;
    wire        sync_pos;
    wire        data_pos;
    wire        cell_pos;
    wire        pos_nxt;
    wire        neg_nxt;
    wire        in_req;

    // ------------------------------------------------------------
    // Edge detection on the clock-like pins
    // ------------------------------------------------------------
    // Pins are synchronous to sys_clk, so a single stage suffices
    assign enc_rise  = enc_clk_in & ~enc_clk_q_r;
    assign send_rise = send_clk_in & ~send_clk_q_r;
    // Half-bit edges split into shift-clock falls and rises
    assign shift_fall = send_rise & shift_clk_r;
    assign shift_rise = send_rise & ~shift_clk_r;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            enc_clk_q_r  <= 1'b0;
            send_clk_q_r <= 1'b0;
        end
        else
        begin
            enc_clk_q_r  <= enc_clk_in;
            send_clk_q_r <= send_clk_in;
        end
    end

    // ------------------------------------------------------------
    // Divide-by-six on the encoder clock
    // ------------------------------------------------------------
    // Toggles every third rise, giving a square wave at one sixth
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            div6_cnt_r <= `MFE_DIV6_ZERO;
            div6_r     <= 1'b0;
        end
        else if (master_rst)
        begin
            div6_cnt_r <= `MFE_DIV6_ZERO;
            div6_r     <= 1'b0;
        end
        else if (enc_rise)
        begin
            if (div6_cnt_r == `MFE_DIV6_LAST)
            begin
                div6_cnt_r <= `MFE_DIV6_ZERO;
                div6_r     <= ~div6_r;
            end
            else
            begin
                div6_cnt_r <= div6_cnt_r + 3'h1;
            end
        end
    end

    assign div6_out = div6_r;

    // ------------------------------------------------------------
    // Shift clock: bit-pair clock divided by two
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            shift_clk_r <= 1'b0;
        else if (master_rst)
            shift_clk_r <= 1'b0;
        else if (send_rise)
            shift_clk_r <= ~shift_clk_r;
    end

    assign tx_bit_strobe_abbrev = shift_clk_r;

    // ------------------------------------------------------------
    // Frame length and word sequencing
    // ------------------------------------------------------------
    // Values below five are undefined lengths; clamp to shortest frame
    assign flen_raw    = {frame_len_bit4, frame_len_bit3, frame_len_bit2,
                          frame_len_bit1, frame_len_bit0};
    assign flen_in     = (flen_raw < `MFE_FLEN_MIN) ? `MFE_FLEN_MIN
                                                    : flen_raw;
    // Periods 0..N make N+1 = K+4 periods per word
    assign last_period = (period_r == flen_r);
    assign start_word  = tx_enable &
                         ((state_r == MFE_ST_IDLE) || last_period);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r  <= MFE_ST_IDLE;
            period_r <= `MFE_PERIOD_ZERO;
            flen_r   <= `MFE_FLEN_MIN;
        end
        else if (master_rst)
        begin
            state_r  <= MFE_ST_IDLE;
            period_r <= `MFE_PERIOD_ZERO;
        end
        else if (shift_fall)
        begin
            case (state_r)
                MFE_ST_IDLE:
                begin
                    if (start_word)
                    begin
                        state_r  <= MFE_ST_WORD;
                        period_r <= `MFE_PERIOD_ZERO;
                        flen_r   <= flen_in;
                    end
                end
                MFE_ST_WORD:
                begin
                    if (start_word)
                    begin
                        period_r <= `MFE_PERIOD_ZERO;
                        flen_r   <= flen_in;
                    end
                    else if (last_period)
                        state_r  <= MFE_ST_IDLE;
                    else
                        period_r <= period_r + `MFE_PERIOD_ONE;
                end
                default:
                    state_r <= MFE_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data request window: periods 2 .. N-2, exactly K periods
    // ------------------------------------------------------------
    assign in_req    = (state_r == MFE_ST_WORD) &&
                       (period_r >= `MFE_REQ_FIRST) &&
                       (period_r <= flen_r - `MFE_REQ_TAIL);
    assign send_data = in_req;

    // ------------------------------------------------------------
    // Rising-edge work: sync type, data sample, line bit
    // ------------------------------------------------------------
    // Line periods start at shift-clock rises, half a period after
    // the word period, so each bit is known before it is sent
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            line_on_r  <= 1'b0;
            line_per_r <= `MFE_PERIOD_ZERO;
            line_bit_r <= 1'b0;
            sync_cmd_r <= 1'b0;
            data_r     <= 1'b0;
            par_acc_r  <= 1'b0;
        end
        else if (master_rst)
        begin
            line_on_r  <= 1'b0;
            par_acc_r  <= 1'b0;
        end
        else if (shift_rise)
        begin
            line_on_r  <= (state_r == MFE_ST_WORD);
            line_per_r <= period_r;
            if (period_r == `MFE_PERIOD_ZERO)
            begin
                sync_cmd_r <= sync_cmd_sel;
                par_acc_r  <= 1'b0;
            end
            if (in_req)
            begin
                data_r    <= tx_payload_in_abbrev;
                par_acc_r <= par_acc_r ^ tx_payload_in_abbrev;
            end
            if (last_period)
                line_bit_r <= par_acc_r ^ parity_odd_sel;
            else
                line_bit_r <= data_r;
        end
    end

    // ------------------------------------------------------------
    // Manchester cell and line outputs
    // ------------------------------------------------------------
    // First half cell while the shift clock is high
    assign in_sync   = (line_per_r < `MFE_LINE_DATA_1ST);
    assign sync_half = {line_per_r[1:0], ~shift_clk_r};
    assign sync_pos  = sync_cmd_r ? (sync_half < `MFE_SYNC_POS_HALF)
                                  : (sync_half >= `MFE_SYNC_POS_HALF);
    assign data_pos  = line_bit_r ? shift_clk_r : ~shift_clk_r;
    assign cell_pos  = in_sync ? sync_pos : data_pos;
    // Inhibit gates only the pins, sequencing runs on untouched
    assign pos_nxt   = ~(line_on_r & out_inhibit_n & cell_pos);
    assign neg_nxt   = ~(line_on_r & out_inhibit_n & ~cell_pos);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pos_n_r <= 1'b1;
            neg_n_r <= 1'b1;
        end
        else
        begin
            pos_n_r <= pos_nxt;
            neg_n_r <= neg_nxt;
        end
    end

    assign line_pos_n = pos_n_r;
    assign line_neg_n = neg_n_r;

endmodule : mfe_encoder

`default_nettype wire

//--- pkg/mfe_defines.svh
// Contract
// - Divide-by-six counter drives its own output pin.
// - Chip reset clears divide-by-two and divide-by-six.
// - Five shared count inputs set frame length.
// - Parity select high gives odd, low even.
// - Start on enable at shift-clock fall, when free.
// - Word cycle lasts K plus four periods.
// - First rise samples sync type: command or data.
// - Data request high for exactly K periods.
// - Serial data sampled on shift-clock rising edges.
// - One parity bit period follows the data.
// - Held enable sends words back to back.
// - Inhibit low forces both line outputs high only.
// - Both line outputs active low, positive and negative.
// - Reset pulse plus clock edge aborts and readies.
// - Three sync, 2 to 28 data, one parity.
// - Count value equals frame length minus one.
`ifndef MFE_DEFINES_SVH
`define MFE_DEFINES_SVH

// ------------------------------------------------------------
// Divider, frame and sync constants
// ------------------------------------------------------------
`define MFE_DIV6_LAST      3'h2
`define MFE_DIV6_ZERO      3'h0
`define MFE_FLEN_MIN       5'h05
`define MFE_PERIOD_ZERO    5'h00
`define MFE_PERIOD_ONE     5'h01
`define MFE_REQ_FIRST      5'h02
`define MFE_LINE_DATA_1ST  5'h03
`define MFE_REQ_TAIL       5'h02
`define MFE_SYNC_POS_HALF  3'h3

`endif

//--- pkg/mfe_pkg.sv
// ------------------------------------------------------------
// Types shared by the encoder
// ------------------------------------------------------------
package mfe_pkg;

    typedef enum logic {
        MFE_ST_IDLE,
        MFE_ST_WORD
    } mfe_state_t;

endpackage : mfe_pkg

//--- tb/mfe_encoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mfe_encoder_monitor
    import mfe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic master_rst,
    input wire logic send_clk_in,
    input wire logic tx_bit_strobe_abbrev,
    input wire logic send_data,
    input wire logic out_inhibit_n,
    input wire logic frame_len_bit0,
    input wire logic frame_len_bit1,
    input wire logic frame_len_bit2,
    input wire logic frame_len_bit3,
    input wire logic frame_len_bit4,
    input wire logic line_pos_n,
    input wire logic line_neg_n
);
    // ------
    // Request length
    // ------
    wire  [4:0] len = {frame_len_bit4, frame_len_bit3, frame_len_bit2,
                       frame_len_bit1, frame_len_bit0};
    wire  [4:0] k   = (len < 5'h05) ? 5'h02 : len - 5'h03;
    logic [4:0] cnt_r;
    // Shift falls since request rose; abort restarts it
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset || master_rst || $rose(send_data))
            cnt_r <= 5'h00;
        else if ($fell(tx_bit_strobe_abbrev))
            cnt_r <= cnt_r + 5'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_req_len;
        $fell(send_data) && !$past(master_rst) |-> cnt_r == k - 5'h01;
    endproperty
    a_req_len: assert property (p_req_len) else $error("bad req");
    property p_req_start;
        $rose(send_data) |-> $fell(tx_bit_strobe_abbrev);
    endproperty
    a_req_start: assert property (p_req_start) else $error("bad go");
    property p_inh;
        !out_inhibit_n && !$past(out_inhibit_n) |-> line_pos_n && line_neg_n;
    endproperty
    a_inh: assert property (p_inh) else $error("inhibit");
    property p_both;
        line_pos_n || line_neg_n;
    endproperty
    a_both: assert property (p_both) else $error("both low");
    // Shift clock follows each bit-pair rise, and nothing else
    property p_shift;
        $rose(send_clk_in) && !master_rst |=> $changed(tx_bit_strobe_abbrev);
    endproperty
    a_shift: assert property (p_shift) else $error("no toggle");
    property p_hold;
        !$rose(send_clk_in) && !master_rst |=> $stable(tx_bit_strobe_abbrev);
    endproperty
    a_hold: assert property (p_hold) else $error("bad toggle");
    property p_mrst;
        master_rst [*3] |-> !tx_bit_strobe_abbrev && !send_data && line_pos_n;
    endproperty
    a_mrst: assert property (p_mrst) else $error("not cleared");
    // Cells move only just after a shift clock edge
    property p_cell;
        $changed(line_pos_n) && out_inhibit_n && !$past(master_rst, 2)
        |-> $past(tx_bit_strobe_abbrev) != $past(tx_bit_strobe_abbrev, 3);
    endproperty
    a_cell: assert property (p_cell) else $error("cell edge");
endmodule : mfe_encoder_monitor
`default_nettype wire

//--- tb/mfe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mfe_host_model
    import mfe_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic tx_bit_strobe_abbrev,
    input  wire logic send_data,
    output var logic  tx_payload_in_abbrev
);
    // ------
    // Serial source
    // ------
    logic bits[$];
    logic st_d = 1'b0;
    initial tx_payload_in_abbrev = 1'b0;
    // New bit after each fall; inverse when not asked, never stale
    always @(negedge sys_clk)
    begin
        st_d <= tx_bit_strobe_abbrev;
        if (st_d && !tx_bit_strobe_abbrev)
            tx_payload_in_abbrev <= (send_data && bits.size() > 0) ?
                bits.pop_front() : ~tx_payload_in_abbrev;
    end
endmodule : mfe_host_model
`default_nettype wire

//--- tb/mfe_encoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mfe_encoder_tb_top
    import mfe_pkg::*;
;
    // Starts low so no false falling edge races the setup at time zero
    logic       sys_clk = 1'b0;
    logic       reset, master_rst, enc_clk_in, send_clk_in, st_d;
    logic       tx_enable, sync_cmd_sel, parity_odd_sel, out_inhibit_n;
    logic       tx_payload_in_abbrev, div6_out, tx_bit_strobe_abbrev;
    logic       send_data, line_pos_n, line_neg_n;
    logic [4:0] len;
    logic [1:0] cells[$], expq[$];
    int         failures, checked, hc, i;
    time        t0;
    mfe_encoder u_mfe_encoder (.sys_clk, .reset, .master_rst, .enc_clk_in,
        .div6_out, .send_clk_in, .tx_bit_strobe_abbrev, .tx_enable,
        .sync_cmd_sel, .parity_odd_sel, .tx_payload_in_abbrev, .send_data,
        .out_inhibit_n, .frame_len_bit0(len[0]), .frame_len_bit1(len[1]),
        .frame_len_bit2(len[2]), .frame_len_bit3(len[3]),
        .frame_len_bit4(len[4]), .line_pos_n, .line_neg_n);
    mfe_host_model u_mfe_host_model (.sys_clk, .tx_bit_strobe_abbrev,
        .send_data, .tx_payload_in_abbrev);
    // ------
    // Clocks and line capture
    // ------
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Divider output looped back as the bit-pair clock
    always @(negedge sys_clk)
    begin
        enc_clk_in  <= ~enc_clk_in;
        send_clk_in <= div6_out;
        st_d        <= tx_bit_strobe_abbrev;
        hc          <= (tx_bit_strobe_abbrev !== st_d) ? 0 : hc + 1;
        if (hc == 5 && {line_pos_n, line_neg_n} !== 2'b11)
            cells.push_back({line_pos_n, line_neg_n});
    end
    task automatic chk(input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %0t got %b exp %b", $time, g, e);
        end
    endtask : chk
    task automatic chk_n(input int g, input int e);
        chk({1'b0, g == e}, 2'b01);
    endtask : chk_n
    // Sync, data cells, then parity; one is positive half first
    function automatic void add_word(bit c, bit o, int k, logic [27:0] d);
        logic [1:0] s;
        s = c ? 2'b01 : 2'b10;
        repeat (3) expq.push_back(s);
        repeat (3) expq.push_back(~s);
        for (int j = 0; j <= k; j++)
        begin
            s = ((j < k) ? d[j] : (^d ^ o)) ? 2'b01 : 2'b10;
            expq.push_back(s);
            expq.push_back(~s);
        end
    endfunction : add_word
    task automatic send_words(int n, logic [4:0] l, bit c, bit o, bit inh);
        logic [27:0] d;
        int          k;
        int          t;
        k = (l < 5'h05) ? 2 : l - 3;
        len = l;
        out_inhibit_n = ~inh;
        sync_cmd_sel = c;
        parity_odd_sel = o;
        repeat (n)
        begin
            d = 28'($urandom) & ((28'h1 << k) - 28'h1);
            for (int j = 0; j < k; j++)
                u_mfe_host_model.bits.push_back(d[j]);
            if (!inh)
                add_word(c, o, k, d);
        end
        tx_enable = 1'b1;
        for (int w = 0; w < n; w++)
        begin
            for (t = 0; t < 900 && send_data !== 1'b1; t++)
                @(negedge sys_clk);
            chk_n(t < 900, 1);
            if (w == 1)
                chk_n(($time - t0) / 20, (k + 4) * 24);
            t0 = $time;
            for (t = 0; t < 900 && send_data !== 1'b0; t++)
                @(negedge sys_clk);
            chk_n(t < 900, 1);
        end
        tx_enable = 1'b0;
        repeat (90) @(negedge sys_clk);
        chk_n(cells.size(), expq.size());
        while (expq.size() > 0 && cells.size() > 0)
            chk(cells.pop_front(), expq.pop_front());
        cells.delete();
        expq.delete();
    endtask : send_words
    task report_and_stop;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // ------
    // Main sequence
    // ------
    initial
    begin
        {reset, master_rst, enc_clk_in, send_clk_in, st_d} = 5'h10;
        {tx_enable, sync_cmd_sel, parity_odd_sel, out_inhibit_n} = 4'h1;
        {len, failures, checked, hc} = '0;
        void'($urandom(32'hB414));
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        @(posedge div6_out);
        t0 = $time;
        @(posedge div6_out);
        chk_n(($time - t0) / 20, 12);
        @(negedge sys_clk);
        for (i = 0; i < 6; i++)
            send_words(i % 2 + 1, (i == 0) ? 5'h05 : (i == 1) ? 5'h1F :
                (i == 2) ? 5'h02 : 5'(5 + $urandom_range(26)),
                i[0], i[1], i == 4);
        tx_enable = 1'b1;
        for (i = 0; i < 900 && send_data !== 1'b1; i++)
            @(negedge sys_clk);
        chk_n(i < 900, 1);
        tx_enable = 1'b0;
        master_rst = 1'b1;
        repeat (30) @(negedge sys_clk);
        master_rst = 1'b0;
        chk({send_data, line_pos_n & line_neg_n}, 2'b01);
        cells.delete();
        send_words(1, 5'h09, 1'b1, 1'b0, 1'b0);
        report_and_stop();
    end
    initial
    begin
        #1000000;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : mfe_encoder_tb_top
bind mfe_encoder mfe_encoder_monitor u_mfe_encoder_monitor (.sys_clk,
    .reset, .master_rst, .send_clk_in, .tx_bit_strobe_abbrev, .send_data,
    .out_inhibit_n, .frame_len_bit0, .frame_len_bit1, .frame_len_bit2,
    .frame_len_bit3, .frame_len_bit4, .line_pos_n, .line_neg_n);
`default_nettype wire
